/* hdl/field_store_pkg.sv */
package field_store_pkg;

	// Memory port shape
	localparam int          DATA_W        = 32;
	localparam int          BURST_BEATS   = 32;
	localparam int          BURST_BYTES   = BURST_BEATS * DATA_W / 8;
	localparam logic [7:0]  AXI_LEN       = 8'h1F;
	localparam logic [2:0]  AXI_SIZE      = 3'h2;
	localparam logic [1:0]  AXI_INCR      = 2'h1;
	localparam int          WR_FIFO_DEPTH = 32;
	localparam int          RD_FIFO_DEPTH = 64;
	localparam logic [1:0]  RD_MAX_OUT    = 2'h2;
	localparam logic [1:0]  NUM_BUF       = 2'h3;
	localparam int          SIZE_W        = 24;
	localparam int          NUM_EVT       = 11;

	// Packer widths: one pixel/error pair per entry
	localparam int          PAIR_W        = 48;
	localparam logic [6:0]  PAIR_BITS_LO  = 7'h28;
	localparam logic [6:0]  PAIR_BITS_HI  = 7'h30;
	localparam logic [6:0]  WORD_BITS     = 7'h20;

	// Register byte offsets
	localparam logic [7:0]  OFS_GLOBAL    = 8'h00;
	localparam logic [7:0]  OFS_STATUS    = 8'h04;
	localparam logic [7:0]  OFS_EVT_STAT  = 8'h08;
	localparam logic [7:0]  OFS_EVT_EN    = 8'h0C;
	localparam logic [7:0]  OFS_PROC_CFG  = 8'h10;
	localparam logic [7:0]  OFS_BUF0      = 8'h24;
	localparam logic [7:0]  OFS_BUF1      = 8'h28;
	localparam logic [7:0]  OFS_BUF2      = 8'h2C;
	localparam logic [7:0]  OFS_BUF_SIZE  = 8'h30;

	// Global register fields and processing-config field
	localparam int          GBL_ENABLE    = 0;
	localparam int          GBL_UPDATE    = 1;
	localparam int          CFG_DEPTH12   = 0;

	// Reset values
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;
	localparam logic [SIZE_W-1:0] RST_SIZE = 24'h00_0400;

	// Event bit positions
	localparam int          EV_COMMIT     = 0;
	localparam int          EV_FRAME      = 1;
	localparam int          EV_WR_DONE    = 2;
	localparam int          EV_RD0_DONE   = 3;
	localparam int          EV_RD1_DONE   = 4;
	localparam int          EV_WR_FULL    = 5;
	localparam int          EV_RD0_UNDER  = 6;
	localparam int          EV_RD1_UNDER  = 7;
	localparam int          EV_CANCEL     = 8;
	localparam int          EV_WR_IGNORED = 9;
	localparam int          EV_RESP_ERR   = 10;

	typedef enum logic [3:0] {
		WR_IDLE = 4'b0001,
		WR_ADDR = 4'b0010,
		WR_DATA = 4'b0100,
		WR_RESP = 4'b1000
	} wr_state_t;

	// AXI address channel payload
	typedef struct packed {
		logic [31:0] addr;
		logic [7:0]  len;
		logic [2:0]  size;
		logic [1:0]  burst;
		logic [0:0]  id;
	} axi_addr_t;

endpackage : field_store_pkg

/* hdl/bit_sync.sv */
// Two-stage synchroniser for levels from another clock domain
module bit_sync
	import field_store_pkg::*;
#(
	parameter int W = 1
)(
	input  wire logic         clk_sys,
	input  wire logic         reset,
	input  wire logic         ce,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_r;

	// First stage is read by the second stage only
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			meta_r   <= '0;
			sync_out <= '0;
		end
		else if (ce)
		begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule : bit_sync

/* hdl/word_fifo.sv */
// Flop-based FIFO; depth must be a power of two
module word_fifo
	import field_store_pkg::*;
#(
	parameter int W     = 32,
	parameter int DEPTH = 32,
	localparam int AW   = $clog2(DEPTH)
)(
	input  wire logic         clk_sys,
	input  wire logic         reset,
	input  wire logic         ce,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic      [W-1:0] out_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [AW:0]  count
);
	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic          push;
	logic          pop;

	// Full and empty straight from the occupancy count
	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem_r[rp_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage
	always_ff @(posedge clk_sys)
	begin
		if (ce && push)
			mem_r[wp_r] <= in_data;
	end

	// Pointers and count
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			count <= '0;
		end
		else if (ce)
		begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule : word_fifo

/* hdl/field_store_master.sv */
// Overview of operation
// RULE1 - Each setting has a staged copy and a working copy updated only on commit.
// RULE2 - While an update is pending, writes to configuration registers are dropped.
// RULE3 - First frame boundary after a pending update copies all staged settings at once.
// RULE4 - Clearing the update bit cancels a pending update at once.
// RULE5 - Eleven events, each with its own sticky flag, enable and clear.
// RULE6 - Register slave handles one bus access at a time.
// RULE7 - A write ahead of a read completes first; the read waits a cycle.
// RULE8 - Memory is three rotating field buffers: one written, two read.
// RULE9 - Each frame end rotates buffer roles to the next buffer.
// RULE10 - Buffer bases and size come from software and may change during operation.
// RULE11 - Buffer size is 24 bits, in 32-bit words.
// RULE12 - One AXI4 master port carries all three streams.
// RULE13 - Pixel/error pairs packed: 5 words per 4 pairs, or 3 per 2.
// RULE14 - Write bursts are 32 beats, length field 31, full width.
// RULE15 - Write beats go back to back; address only once the burst is stored.
// RULE16 - Only one write transaction outstanding.
// RULE17 - Read issued only with room for the whole burst; read ready held high.
// RULE18 - Read bursts are 32 beats at full width.
// RULE19 - Read streams use IDs 0 and 1; returning beats steered by ID.
// RULE20 - Up to two reads outstanding per stream, four in total.
// RULE21 - Memory slave accepts four pending reads and tags data with its ID.
// RULE22 - Memory slave may stall writes and gap reads; nothing is lost.
// RULE23 - Burst addresses step by burst size from base, restarting each field.
module field_store_master
	import field_store_pkg::*;
(
	input  wire logic                clk_sys,
	input  wire logic                reset,
	input  wire logic                ce,
	// AHB-Lite register slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic      [31:0]         hrdata,
	// Video-side frame timing, from the video clock domain
	input  wire logic                vid_clk,
	input  wire logic                frame_end,
	output logic      [31:0]         cfg_active,
	output logic                     irq,
	// Write stream source: pixel/error pairs
	input  wire logic [PAIR_W-1:0]   pair_data,
	input  wire logic                pair_valid,
	output logic                     pair_ready,
	// Read stream sinks
	output logic      [1:0][31:0]    rd_data,
	output logic      [1:0]          rd_valid,
	input  wire logic [1:0]          rd_ready,
	// AXI4 master
	output logic                     m_awvalid,
	input  wire logic                m_awready,
	output axi_addr_t                m_aw,
	output logic                     m_wvalid,
	input  wire logic                m_wready,
	output logic      [DATA_W-1:0]   m_wdata,
	output logic      [DATA_W/8-1:0] m_wstrb,
	output logic                     m_wlast,
	input  wire logic                m_bvalid,
	input  wire logic [1:0]          m_bresp,
	output logic                     m_bready,
	output logic                     m_arvalid,
	input  wire logic                m_arready,
	output axi_addr_t                m_ar,
	input  wire logic                m_rvalid,
	input  wire logic [DATA_W-1:0]   m_rdata,
	input  wire logic [0:0]          m_rid,
	input  wire logic                m_rlast,
	input  wire logic [1:0]          m_rresp,
	output logic                     m_rready
);
	// Register side
	logic                ahb_go;
	logic                wr_ph_r;
	logic                rd_ph_r;
	logic [7:0]          acc_addr_r;
	logic                enable_r;
	logic                upd_pend_r;
	logic                gbl_wr;
	logic                cfg_wr;
	logic                commit;
	logic [31:0]         base_s_r [3];
	logic [31:0]         base_w_r [3];
	logic [SIZE_W-1:0]   size_s_r;
	logic [SIZE_W-1:0]   size_w_r;
	logic [31:0]         cfg_s_r;
	logic [NUM_EVT-1:0]  evt;
	logic [NUM_EVT-1:0]  evt_stat_r;
	logic [NUM_EVT-1:0]  evt_en_r;
	logic [31:0]         rd_mux;
	// Frame timing
	logic [1:0]          link_s;
	logic                vclk_d_r;
	logic                frame_tick;
	// Buffer rotation and addressing
	logic [1:0]          wr_idx_r;
	logic [1:0]          rd_idx [2];
	logic [25:0]         size_bytes;
	logic [25:0]         wr_off_r;
	logic [25:0]         rd_off_r [2];
	// Packer
	logic [95:0]         acc_r;
	logic [6:0]          fill_r;
	logic [6:0]          pair_bits;
	logic                pk_valid;
	logic                pk_ready;
	logic                pair_take;
	// Write path
	wr_state_t           wr_st_r;
	logic [4:0]          beat_r;
	logic [5:0]          wf_count;
	logic                w_hs;
	// Read path
	logic [1:0]          rd_out_r [2];
	logic [6:0]          rf_count [2];
	logic [1:0]          rf_push;
	logic [1:0]          room_ok;
	logic                rd_pick;
	logic                rd_prio_r;
	logic [1:0]          rd_last_hs;

	// One transfer at a time: address phase captured, data phase follows
	assign ahb_go = hsel && htrans[1] && hready; // RULE6
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			wr_ph_r    <= 1'b0;
			rd_ph_r    <= 1'b0;
			acc_addr_r <= 8'h00;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
			hrdata     <= RST_WORD;
		end
		else if (ce)
		begin
			wr_ph_r   <= ahb_go && hwrite;
			rd_ph_r   <= ahb_go && !hwrite;
			// Read takes one wait state so a preceding write lands first
			hreadyout <= !(ahb_go && !hwrite); // RULE7
			if (ahb_go)
				acc_addr_r <= haddr[7:0];
			if (rd_ph_r)
				hrdata <= rd_mux; // RULE7
		end
	end

	// Read decode; unmapped offsets read zero
	always_comb
	begin
		rd_mux = RST_WORD;
		case (acc_addr_r)
			OFS_GLOBAL:   rd_mux = {30'h0, upd_pend_r, enable_r};
			OFS_STATUS:   rd_mux = {24'h0, rd_out_r[1], rd_out_r[0], wr_idx_r, 2'h0};
			OFS_EVT_STAT: rd_mux = {21'h0, evt_stat_r};
			OFS_EVT_EN:   rd_mux = {21'h0, evt_en_r};
			OFS_PROC_CFG: rd_mux = cfg_s_r;
			OFS_BUF0:     rd_mux = base_s_r[0];
			OFS_BUF1:     rd_mux = base_s_r[1];
			OFS_BUF2:     rd_mux = base_s_r[2];
			OFS_BUF_SIZE: rd_mux = {8'h00, size_s_r}; // RULE11
			default:      rd_mux = RST_WORD;
		endcase
	end

	// Global register and update scheduling
	assign gbl_wr = wr_ph_r && (acc_addr_r == OFS_GLOBAL);
	assign commit = upd_pend_r && frame_tick && !gbl_wr; // RULE3 RULE4
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			enable_r   <= 1'b0;
			upd_pend_r <= 1'b0;
		end
		else if (ce)
		begin
			if (gbl_wr)
			begin
				enable_r   <= hwdata[GBL_ENABLE];
				// Software write, including a cancel, overrides the commit
				upd_pend_r <= hwdata[GBL_UPDATE]; // RULE4
			end
			else if (commit)
				upd_pend_r <= 1'b0;
		end
	end

	// Staged copies; frozen while an update is queued
	assign cfg_wr = wr_ph_r && !upd_pend_r; // RULE2
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			base_s_r <= '{default: RST_WORD};
			size_s_r <= RST_SIZE;
			cfg_s_r  <= RST_WORD;
		end
		else if (ce && cfg_wr)
		begin
			case (acc_addr_r)
				OFS_BUF0:     base_s_r[0] <= hwdata; // RULE10
				OFS_BUF1:     base_s_r[1] <= hwdata;
				OFS_BUF2:     base_s_r[2] <= hwdata;
				OFS_BUF_SIZE: size_s_r    <= hwdata[SIZE_W-1:0]; // RULE11
				OFS_PROC_CFG: cfg_s_r     <= hwdata;
				default:      ;
			endcase
		end
	end

	// Working copies change only at commit, all together
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			base_w_r   <= '{default: RST_WORD};
			size_w_r   <= RST_SIZE;
			cfg_active <= RST_WORD;
		end
		else if (ce && commit)
		begin
			base_w_r   <= base_s_r; // RULE1 RULE3
			size_w_r   <= size_s_r;
			cfg_active <= cfg_s_r;
		end
	end

	// Event collection
	always_comb
	begin
		evt                = '0;
		evt[EV_COMMIT]     = commit;
		evt[EV_FRAME]      = frame_tick;
		evt[EV_WR_DONE]    = wr_st_r[3] && m_bvalid;
		evt[EV_RD0_DONE]   = rd_last_hs[0];
		evt[EV_RD1_DONE]   = rd_last_hs[1];
		evt[EV_WR_FULL]    = pk_valid && !pk_ready;
		evt[EV_RD0_UNDER]  = enable_r && rd_ready[0] && !rd_valid[0];
		evt[EV_RD1_UNDER]  = enable_r && rd_ready[1] && !rd_valid[1];
		evt[EV_CANCEL]     = gbl_wr && upd_pend_r && !hwdata[GBL_UPDATE];
		evt[EV_WR_IGNORED] = wr_ph_r && upd_pend_r && (acc_addr_r != OFS_GLOBAL)
			&& (acc_addr_r != OFS_EVT_STAT) && (acc_addr_r != OFS_EVT_EN);
		evt[EV_RESP_ERR]   = (wr_st_r[3] && m_bvalid && m_bresp[1])
			|| (m_rvalid && m_rresp[1]);
	end

	// Sticky flags, write-one-to-clear; a new event beats the clear
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			evt_stat_r <= '0;
			evt_en_r   <= '0;
			irq        <= 1'b0;
		end
		else if (ce)
		begin
			if (wr_ph_r && acc_addr_r == OFS_EVT_STAT)
				evt_stat_r <= (evt_stat_r & ~hwdata[NUM_EVT-1:0]) | evt; // RULE5
			else
				evt_stat_r <= evt_stat_r | evt;
			if (wr_ph_r && acc_addr_r == OFS_EVT_EN)
				evt_en_r <= hwdata[NUM_EVT-1:0]; // RULE5
			irq <= |(evt_stat_r & evt_en_r);
		end
	end

	// Frame boundary: sample the synced end flag on each video clock rise
	bit_sync #(.W(2)) u_link_sync (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.ce       (ce),
		.async_in ({frame_end, vid_clk}),
		.sync_out (link_s)
	);
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			vclk_d_r <= 1'b0;
		else if (ce)
			vclk_d_r <= link_s[0];
	end
	assign frame_tick = link_s[0] && !vclk_d_r && link_s[1];

	// Buffer rotation: write role moves on; readers take the two older fields
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			wr_idx_r <= 2'h0;
		else if (ce && frame_tick)
			wr_idx_r <= (wr_idx_r == NUM_BUF - 2'h1) ? 2'h0 : wr_idx_r + 2'h1; // RULE9
	end
	assign rd_idx[0] = (wr_idx_r == 2'h0) ? 2'h2 : wr_idx_r - 2'h1; // RULE8
	assign rd_idx[1] = (wr_idx_r == 2'h2) ? 2'h0 : wr_idx_r + 2'h1;
	assign size_bytes = {size_w_r, 2'b00};

	// Packer: pairs of 40 or 48 bits folded into 32-bit words
	assign pair_bits = cfg_active[CFG_DEPTH12] ? PAIR_BITS_HI : PAIR_BITS_LO; // RULE13
	assign pk_valid  = (fill_r >= WORD_BITS);
	assign pair_take = pair_valid && pair_ready;
	always_ff @(posedge clk_sys)
	begin
		logic [6:0]  f;
		logic [95:0] a;
		f = fill_r;
		a = acc_r;
		if (reset)
		begin
			acc_r      <= '0;
			fill_r     <= 7'h00;
			pair_ready <= 1'b0;
		end
		else if (ce)
		begin
			if (pk_valid && pk_ready)
			begin
				a = a >> WORD_BITS;
				f = f - WORD_BITS;
			end
			if (pair_take)
			begin
				a = a | ({48'h0, pair_data & ~({PAIR_W{1'b1}} << pair_bits)} << f); // RULE13
				f = f + pair_bits;
			end
			acc_r      <= a;
			fill_r     <= f;
			pair_ready <= (f < WORD_BITS);
		end
	end

	word_fifo #(.W(DATA_W), .DEPTH(WR_FIFO_DEPTH)) u_wr_fifo (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.ce        (ce),
		.in_data   (acc_r[31:0]),
		.in_valid  (pk_valid),
		.in_ready  (pk_ready),
		.out_data  (m_wdata), // RULE12
		.out_valid (),
		.out_ready (w_hs),
		.count     (wf_count)
	);

	// Write channel: address only when a whole burst is stored, one at a time
	assign m_awvalid = wr_st_r[1];
	assign m_wvalid  = wr_st_r[2]; // RULE15
	assign w_hs      = m_wvalid && m_wready; // RULE22
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			wr_st_r  <= WR_IDLE;
			beat_r   <= 5'h00;
			m_wlast  <= 1'b0;
			m_aw     <= '0;
			wr_off_r <= '0;
			m_wstrb  <= '1;
			m_bready <= 1'b1;
		end
		else if (ce)
		begin
			if (frame_tick)
				wr_off_r <= '0; // RULE23
			case (wr_st_r)
				WR_IDLE:
					if (enable_r && wf_count >= 6'(BURST_BEATS)) // RULE15 RULE16
					begin
						m_aw    <= '{addr: base_w_r[wr_idx_r] + 32'(wr_off_r), len: AXI_LEN,
							size: AXI_SIZE, burst: AXI_INCR, id: 1'b0}; // RULE8 RULE14
						wr_st_r <= WR_ADDR;
					end
				WR_ADDR:
					if (m_awready)
					begin
						if (!frame_tick)
							wr_off_r <= (wr_off_r + 26'(BURST_BYTES) >= size_bytes) ? '0
								: wr_off_r + 26'(BURST_BYTES); // RULE23
						beat_r  <= 5'h00;
						m_wlast <= 1'b0;
						wr_st_r <= WR_DATA;
					end
				WR_DATA:
					if (w_hs)
					begin
						beat_r  <= beat_r + 5'h01;
						m_wlast <= (beat_r == 5'h1E); // RULE14
						if (m_wlast)
							wr_st_r <= WR_RESP;
					end
				WR_RESP:
					if (m_bvalid)
						wr_st_r <= WR_IDLE; // RULE16
				default: wr_st_r <= WR_IDLE;
			endcase
		end
	end

	// Read buffers, one per stream; each must hold every requested beat
	assign m_rready = 1'b1 & !reset; // RULE17
	generate
		for (genvar s = 0; s < 2; s++)
		begin : g_rd
			assign rf_push[s]    = m_rvalid && (m_rid == 1'(s)); // RULE19 RULE21
			assign rd_last_hs[s] = rf_push[s] && m_rlast;
			assign room_ok[s]    = enable_r && (rd_out_r[s] < RD_MAX_OUT) &&
				(({1'b0, rf_count[s]} + {1'b0, rd_out_r[s], 5'h00}) <= 8'(RD_FIFO_DEPTH
				- BURST_BEATS)); // RULE17 RULE20
			word_fifo #(.W(DATA_W), .DEPTH(RD_FIFO_DEPTH)) u_rd_fifo (
				.clk_sys   (clk_sys),
				.reset     (reset),
				.ce        (ce),
				.in_data   (m_rdata),
				.in_valid  (rf_push[s]),
				.in_ready  (),
				.out_data  (rd_data[s]),
				.out_valid (rd_valid[s]),
				.out_ready (rd_ready[s]),
				.count     (rf_count[s])
			);
			// Outstanding count: up on address accept, down on last beat
			always_ff @(posedge clk_sys)
			begin
				if (reset)
					rd_out_r[s] <= 2'h0;
				else if (ce)
					rd_out_r[s] <= rd_out_r[s] + 2'(m_arvalid && m_arready && m_ar.id == 1'(s))
						- 2'(rd_last_hs[s]); // RULE20
			end
		end
	endgenerate

	// Read address issue, alternating priority between streams
	assign rd_pick = room_ok[1] && (!room_ok[0] || rd_prio_r);
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			m_arvalid <= 1'b0;
			m_ar      <= '0;
			rd_prio_r <= 1'b0;
			rd_off_r  <= '{default: '0};
		end
		else if (ce)
		begin
			if (m_arvalid && m_arready)
			begin
				m_arvalid <= 1'b0;
				rd_off_r[m_ar.id] <= (rd_off_r[m_ar.id] + 26'(BURST_BYTES) >= size_bytes) ? '0
					: rd_off_r[m_ar.id] + 26'(BURST_BYTES); // RULE23
			end
			else if (!m_arvalid && |room_ok && !frame_tick)
			begin
				m_arvalid <= 1'b1;
				m_ar      <= '{addr: base_w_r[rd_idx[rd_pick]] + 32'(rd_off_r[rd_pick]),
					len: AXI_LEN, size: AXI_SIZE, burst: AXI_INCR, id: rd_pick}; // RULE18 RULE19
				rd_prio_r <= !rd_pick;
			end
			if (frame_tick)
				rd_off_r <= '{default: '0}; // RULE23
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	aw_len_fixed_a: assert property (m_awvalid |-> m_aw.len == AXI_LEN && m_aw.size == AXI_SIZE) // RULE14
		else $error("write burst not 32 full-width beats");
	aw_burst_ready_a: assert property ($rose(m_awvalid) |-> wf_count >= 6'(BURST_BEATS)) // RULE15
		else $error("write address issued before burst stored");
	one_write_a: assert property (ce && m_awvalid && m_awready |=> !m_awvalid [*2]) // RULE16
		else $error("second write address while one outstanding");
	rready_high_a: assert property (m_rready) // RULE17
		else $error("read ready dropped");
	ar_shape_a: assert property (m_arvalid |-> m_ar.len == AXI_LEN && m_ar.size == AXI_SIZE) // RULE18
		else $error("read burst not 32 full-width beats");
	rd_outstanding_a: assert property (rd_out_r[0] <= RD_MAX_OUT && rd_out_r[1] <= RD_MAX_OUT) // RULE20
		else $error("more than two reads outstanding on a stream");
	commit_copy_a: assert property (ce && commit |=> !upd_pend_r && size_w_r == $past(size_s_r)) // RULE3
		else $error("commit did not copy staged settings");
	frozen_cfg_a: assert property (ce && upd_pend_r && wr_ph_r |=> $stable(base_s_r[0]) && $stable(size_s_r)) // RULE2
		else $error("staged register changed while update pending");
	read_stall_a: assert property (ce && ahb_go && !hwrite |=> !hreadyout ##1 hreadyout) // RULE7
		else $error("read not stalled for one cycle");
	cancel_now_a: assert property (ce && gbl_wr && !hwdata[GBL_UPDATE] |=> !upd_pend_r && !commit) // RULE4
		else $error("cancel did not take effect at once");

endmodule : field_store_master

/* sim/axi_mem_model.sv */
// Memory-side slave: stalls write data and gaps read data on purpose
module axi_mem_model
	import field_store_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire logic              m_awvalid,
	output logic                   m_awready,
	input  wire logic              m_wvalid,
	output logic                   m_wready,
	input  wire logic              m_wlast,
	output logic                   m_bvalid,
	input  wire logic              m_bready,
	input  wire logic              m_arvalid,
	output logic                   m_arready,
	input  axi_addr_t              m_ar,
	output logic                   m_rvalid,
	output logic      [DATA_W-1:0] m_rdata,
	output logic      [0:0]        m_rid,
	output logic                   m_rlast,
	input  wire logic              m_rready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cyc;
	logic [4:0] beat;
	logic       wbusy;
	int         nq;
	axi_addr_t  q[$];
	assign m_awready = !wbusy;
	assign m_wready  = wbusy && cyc[1:0] != 2'h0;
	assign m_arready = nq < 4;
	// One write burst at a time, answered after its last beat
	always @(posedge clk_sys)
	begin
		cyc <= reset ? 8'h00 : cyc + 8'h01;
		if (reset || (m_bvalid && m_bready))
		begin
			wbusy    <= 1'b0;
			m_bvalid <= 1'b0;
		end
		else if (m_awvalid && m_awready)
			wbusy <= 1'b1;
		else if (m_wvalid && m_wready && m_wlast)
			m_bvalid <= 1'b1;
	end
	// Bursts return in order with their ID; idle data flips so stale beats never match
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			q.delete();
			beat = 5'h00;
		end
		else
		begin
			if (m_rvalid && m_rready && m_rlast)
			begin
				void'(q.pop_front());
				beat = 5'h00;
			end
			else if (m_rvalid && m_rready)
				beat = beat + 5'h01;
			if (m_arvalid && m_arready)
				q.push_back(m_ar);
		end
		nq       <= q.size();
		m_rvalid <= q.size() > 0 && cyc[0];
		m_rid    <= q.size() > 0 ? q[0].id : ~m_rid;
		m_rlast  <= beat == 5'h1F;
		m_rdata  <= q.size() > 0 && cyc[0] ? q[0].addr + beat * 4 : ~m_rdata;
	end
endmodule : axi_mem_model

/* sim/field_store_master_tb.sv */
module field_store_master_tb
	import field_store_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, reset, vid_clk, frame_end, pair_valid, pair_ready, irq, hwrite;
	logic hreadyout, hresp, m_awvalid, m_awready, m_wvalid, m_wready, m_wlast, m_bvalid;
	logic m_bready, m_arvalid, m_arready, m_rvalid, m_rlast, m_rready;
	logic [1:0] htrans, rd_valid, rd_ready;
	logic [31:0] haddr, hwdata, hrdata, cfg_active;
	logic [PAIR_W-1:0] pair_data;
	logic [1:0][31:0] rd_data;
	logic [DATA_W-1:0] m_wdata, m_rdata;
	logic [DATA_W/8-1:0] m_wstrb;
	logic [0:0] m_rid;
	axi_addr_t m_aw, m_ar;
	int n_fail, num_checks, nfr, naw, nbt, woff, wout, cyc, k;
	int roff[2], rout[2];
	logic [31:0] bas[3] = '{32'h1000_0000, 32'h2000_0000, 32'h3000_0000};
	field_store_master uut (.clk_sys, .reset, .ce(1'b1), .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .vid_clk,
		.frame_end, .cfg_active, .irq, .pair_data, .pair_valid, .pair_ready, .rd_data, .rd_valid,
		.rd_ready, .m_awvalid, .m_awready, .m_aw, .m_wvalid, .m_wready, .m_wdata, .m_wstrb,
		.m_wlast, .m_bvalid, .m_bresp(2'h0), .m_bready, .m_arvalid, .m_arready, .m_ar, .m_rvalid,
		.m_rdata, .m_rid, .m_rlast, .m_rresp(2'h0), .m_rready);
	axi_mem_model mem (.clk_sys, .reset, .m_awvalid, .m_awready, .m_wvalid, .m_wready, .m_wlast,
		.m_bvalid, .m_bready, .m_arvalid, .m_arready, .m_ar, .m_rvalid, .m_rdata, .m_rid,
		.m_rlast, .m_rready);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Single AHB transfer; each phase held until hready is high at an edge
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h00_0000, a};
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : ahb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		ahb(1'b1, a, d, v);
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		ahb(1'b0, a, 32'h0, v);
		chk("register", v, exp);
	endtask : rchk
	// Frame end is high across exactly one video clock rise
	task automatic frame;
		@(negedge vid_clk) frame_end <= 1'b1;
		@(negedge vid_clk) frame_end <= 1'b0;
		repeat (6) @(posedge clk_sys);
		nfr++;
		woff = 0;
		roff = '{0, 0};
	endtask : frame
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Video clock is unrelated in phase to the system clock
	initial
	begin
		vid_clk = 1'b0;
		#130;
		forever #400 vid_clk = ~vid_clk;
	end
	always @(posedge clk_sys)
	begin
		cyc++;
		if (pair_valid && pair_ready)
			pair_data <= pair_data + 48'h0000_0000_0001;
		if (cyc == 20000)
		begin
			n_fail++;
			tally_and_finish;
		end
	end
	// Memory port monitor, sampled mid-cycle where handshakes are settled
	always @(negedge clk_sys)
	begin
		if (reset === 1'b0)
		begin
			chk("rready", m_rready, 1'b1);
			if (m_awvalid && m_awready)
			begin
				chk("awlen", m_aw.len, AXI_LEN);
				chk("awaddr", m_aw.addr, bas[nfr % 3] + woff);
				chk("wr_out", wout, 0);
				wout = 1;
				woff += BURST_BYTES;
				naw++;
			end
			if (m_wvalid && m_wready)
			begin
				k = (naw - 1) * 32 + nbt;
				chk("wdata", m_wdata, k % 3 > 1 ? 0 : (k / 3 * 2 + k % 3) << k % 3 * 16);
				nbt++;
			end
			if (m_wvalid && m_wready && m_wlast)
			begin
				chk("beats", nbt, 32);
				nbt = 0;
			end
			if (m_bvalid && m_bready)
				wout = 0;
			if (m_arvalid && m_arready)
			begin
				chk("araddr", m_ar.addr, bas[(nfr + 2 - m_ar.id) % 3] + roff[m_ar.id]);
				chk("arlen", m_ar.len, AXI_LEN);
				chk("rd_out", rout[m_ar.id] < 2, 1'b1);
				rout[m_ar.id]++;
				roff[m_ar.id] += BURST_BYTES;
			end
			if (m_rvalid && m_rready && m_rlast)
				rout[m_rid]--;
			for (int s = 0; s < 2; s++)
				if (rd_valid[s] && rd_ready[s])
					chk("steer", rd_data[s][31:28], (nfr + 2 - s) % 3 + 1);
		end
	end
	initial
	begin
		{htrans, hwrite, haddr, hwdata, frame_end, pair_valid, pair_data, rd_ready} = '0;
		reset = 1'b1;
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		rchk(OFS_BUF_SIZE, {8'h00, RST_SIZE});
		rchk(OFS_EVT_STAT, 32'h0);
		for (int i = 0; i < 3; i++)
			wr(OFS_BUF0 + 8'(4 * i), bas[i]);
		wr(OFS_BUF_SIZE, 32'hFF00_0400);
		rchk(OFS_BUF_SIZE, 32'h0000_0400);
		wr(OFS_PROC_CFG, 32'h0000_0001);
		rchk(OFS_PROC_CFG, 32'h0000_0001);
		wr(8'hFC, 32'hFFFF_FFFF);
		rchk(8'hFC, 32'h0);
		$display("staging test ended");
		wr(OFS_GLOBAL, 32'h0000_0002);
		wr(OFS_PROC_CFG, 32'h0000_0007);
		rchk(OFS_PROC_CFG, 32'h0000_0001);
		rchk(OFS_GLOBAL, 32'h0000_0002);
		chk("cfg_active", cfg_active, 32'h0);
		frame;
		chk("cfg_active", cfg_active, 32'h0000_0001);
		rchk(OFS_EVT_STAT, 32'h0000_0203);
		wr(OFS_EVT_EN, 32'h0000_0001);
		repeat (3) @(posedge clk_sys);
		chk("irq", irq, 1'b1);
		wr(OFS_EVT_STAT, 32'h0000_0201);
		rchk(OFS_EVT_STAT, 32'h0000_0002);
		repeat (3) @(posedge clk_sys);
		chk("irq", irq, 1'b0);
		$display("commit test ended");
		wr(OFS_GLOBAL, 32'h0);
		wr(OFS_PROC_CFG, 32'h0);
		wr(OFS_GLOBAL, 32'h0000_0002);
		wr(OFS_GLOBAL, 32'h0);
		frame;
		chk("cfg_active", cfg_active, 32'h0000_0001);
		$display("cancel test ended");
		rd_ready <= 2'h3;
		pair_valid <= 1'b1;
		wr(OFS_GLOBAL, 32'h0000_0001);
		repeat (1000) @(posedge clk_sys);
		chk("bursts", naw > 2, 1'b1);
		$display("stream test ended");
		tally_and_finish;
	end
endmodule : field_store_master_tb
